// [bench/bsram_host_model.sv]
// host-side model of the shared data pins of the burst sram core
// assumes the bench flags each cycle in which the host drives write data
`timescale 1ns/1ps
`default_nettype none
`include "bsram_cfg.svh"
module bsram_host_model (
    input wire logic clk,
    input wire logic host_drive,
    input wire logic [`BSRAM_DW-1:0] host_data,
    input wire logic [`BSRAM_DW-1:0] core_data,
    input wire logic core_oe_n,
    output logic [`BSRAM_DW-1:0] pin_data
);
    logic [`BSRAM_DW-1:0] idle_r = 18'h15555;
    // released pins show a pattern that flips every cycle
    always @(posedge clk) begin
        idle_r <= ~idle_r;
    end
    // core drives on reads, host only in its write-data cycles
    assign pin_data = !core_oe_n ? core_data : (host_drive ? host_data : idle_r);
endmodule : bsram_host_model
`default_nettype wire

// [bench/burst_sync_sram_core_tb.sv]
// self-checking bench of the burst sram core: directed bursts plus seeded random traffic
// assumes the core and the host pin model; expectations come from a reference memory
`timescale 1ns/1ps
`default_nettype none
`include "bsram_cfg.svh"
module burst_sync_sram_core_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] k_r = 6'h3F;
    logic [15:0] a_r = 16'h0000;
    logic [17:0] d_r = 18'h00000;
    logic g_n = 1'b1;
    logic hdrv = 1'b0;
    logic [17:0] pin_i, core_o;
    logic oe_n;
    logic [17:0] mem [int];
    logic [15:0] base_r = 16'h0000;
    logic [1:0] cnt_r = 2'h0;
    logic alive_r = 1'b0;
    logic p_rd [2] = '{1'b0, 1'b0};
    logic [17:0] p_d [2];
    logic [15:0] b;
    int failures = 0;
    int num_checks = 0;
    // clock and control order {proc, ctrl, cs, step, low, high}
    always #20 clk = ~clk;
    bsram_core u_bsram_core (.clk(clk), .rst(rst), .addr_in(a_r), .chip_sel_n(k_r[3]),
        .processor_addr_strobe_n(k_r[5]), .controller_addr_strobe_n(k_r[4]), .burst_step_n(k_r[2]),
        .low_byte_wr_n(k_r[1]), .high_byte_wr_n(k_r[0]), .out_en_n(g_n), .data_io_i(pin_i),
        .data_io_o(core_o), .data_io_oe_n(oe_n));
    bsram_host_model u_bsram_host_model (.clk(clk), .host_drive(hdrv), .host_data(d_r),
        .core_data(core_o), .core_oe_n(oe_n), .pin_data(pin_i));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [17:0] s, input logic [17:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    // burst address of step n: upper bits kept, low bits interleaved by the count
    function automatic logic [15:0] burst_addr(input logic [15:0] base, input logic [1:0] n);
        return {base[15:2], base[1:0] ^ n};
    endfunction : burst_addr
    // one bus cycle: drive, check the op of two cycles back, predict this one
    task automatic cyc(input logic [5:0] k, input logic [15:0] ad, input logic [17:0] d, input logic g);
        logic wr;
        logic [15:0] ea;
        @(posedge clk);
        k_r <= k;
        a_r <= ad;
        d_r <= d;
        hdrv <= ~(k[1] & k[0]);
        g_n <= g | ~(k[1] & k[0]);
        #1;
        chk({17'h0, oe_n}, {17'h0, ~(p_rd[1] & ~g_n)});
        chk({17'h0, ~oe_n & hdrv}, 18'h00000);
        if (p_rd[1] && !g_n) chk(core_o, p_d[1]);
        if (!k[5] || !k[4]) begin
            alive_r = ~k[3];
            base_r = ad;
            cnt_r = 2'h0;
        end else if (!k[2]) begin
            cnt_r = cnt_r + 2'h1;
        end
        wr = alive_r & k[5] & ~(k[1] & k[0]);
        ea = burst_addr(base_r, cnt_r);
        if (wr && !k[1]) mem[ea][8:0] = d[8:0];
        if (wr && !k[0]) mem[ea][17:9] = d[17:9];
        p_rd[1] = p_rd[0];
        p_d[1] = p_d[0];
        p_rd[0] = alive_r & ~wr;
        p_d[0] = mem.exists(ea) ? mem[ea] : 18'h3FFFF;
    endtask : cyc
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'h14C18233));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({17'h0, oe_n}, 18'h00001);
        b = $urandom;
        cyc(6'h20, b, $urandom, 1'b0);
        repeat (3) cyc(6'h30, 16'h0000, $urandom, 1'b0);
        cyc(6'h10, b ^ 16'h0003, 18'h00000, 1'b0);
        repeat (5) cyc(6'h33, 16'h0000, 18'h00000, 1'b0);
        repeat (2) cyc(6'h37, 16'h0000, 18'h00000, 1'b0);
        $display("test burst done");
        cyc(6'h21, b, $urandom, 1'b0);
        cyc(6'h22, b, $urandom, 1'b0);
        cyc(6'h13, b, 18'h00000, 1'b0);
        cyc(6'h3C, 16'h0000, $urandom, 1'b0);
        cyc(6'h23, b, 18'h00000, 1'b0);
        cyc(6'h23, b, 18'h00000, 1'b0);
        $display("test lanes done");
        cyc(6'h1B, b, 18'h00000, 1'b1);
        cyc(6'h33, b, 18'h00000, 1'b0);
        cyc(6'h23, b, 18'h00000, 1'b0);
        cyc(6'h2F, b, 18'h00000, 1'b0);
        repeat (2) cyc(6'h3F, 16'h0000, 18'h00000, 1'b0);
        $display("test deselect done");
        // fill the sixteen words the random traffic may touch
        for (int i = 0; i < 4; i++) begin
            cyc(6'h20, {b[15:4], 2'(i), 2'h0}, $urandom, 1'b0);
            repeat (3) cyc(6'h30, 16'h0000, $urandom, 1'b0);
        end
        repeat (250) cyc(6'($urandom), {b[15:4], 4'($urandom)}, 18'($urandom), 1'($urandom));
        repeat (2) cyc(6'h2F, 16'h0000, 18'h00000, 1'b0);
        $display("test random done");
        summarize();
    end
    // watchdog well beyond the few hundred cycles of the tests
    initial begin
        #80000;
        failures++;
        summarize();
    end
endmodule : burst_sync_sram_core_tb
`default_nettype wire

// [verilog/bsram_array.sv]
// storage array of the burst sram, one flip-flop bank per byte lane
// assumes the core presents registered address, data and lane enables
`timescale 1ns/1ps
`default_nettype none
`include "bsram_cfg.svh"
module bsram_array (
    input wire logic clk,
    input wire logic [`BSRAM_AW-1:0] addr,
    input wire logic [`BSRAM_LANES-1:0] lane_we,
    input wire logic [`BSRAM_DW-1:0] wdata,
    output logic [`BSRAM_DW-1:0] rdata
);
    // ----------------------------------------------------------------
    // byte lanes
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `BSRAM_LANES; g = g + 1) begin : g_lane
            logic [`BSRAM_LANE_W-1:0] mem [0:`BSRAM_DEPTH-1];
            // lane written only when its own enable was sampled
            always_ff @(posedge clk) begin
                if (lane_we[g]) begin
                    mem[addr] <= wdata[g*`BSRAM_LANE_W +: `BSRAM_LANE_W];
                end
            end
            assign rdata[g*`BSRAM_LANE_W +: `BSRAM_LANE_W] = mem[addr];
        end
    endgenerate
endmodule : bsram_array
`default_nettype wire

// [verilog/bsram_cfg.svh]
// constants for the burst synchronous sram core: widths, depth, reset values
// assumes one rising-edge clock and an active-high asynchronous reset
`ifndef BSRAM_CFG_SVH
`define BSRAM_CFG_SVH
`define BSRAM_AW 16
`define BSRAM_DW 18
`define BSRAM_LANE_W 9
`define BSRAM_LANES 2
`define BSRAM_DEPTH 65536
`define BSRAM_CNT_W 2
`define BSRAM_ADDR_RST 16'h0000
`define BSRAM_DATA_RST 18'h00000
`define BSRAM_CNT_RST 2'h0
`define BSRAM_WE_RST 2'h0
`endif

// [verilog/bsram_core.sv]
// burst synchronous sram core: input registers, burst counter, array, output register
// assumes synchronous host inputs and a board-level resolver for the data pins
`timescale 1ns/1ps
`default_nettype none
`include "bsram_cfg.svh"
module bsram_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`BSRAM_AW-1:0] addr_in,
    input wire logic chip_sel_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic low_byte_wr_n,
    input wire logic high_byte_wr_n,
    input wire logic out_en_n,
    input wire logic [`BSRAM_DW-1:0] data_io_i,
    output logic [`BSRAM_DW-1:0] data_io_o,
    output logic data_io_oe_n
);
    // ----------------------------------------------------------------
    // input decode
    // ----------------------------------------------------------------
    logic strobe;
    logic load_ok;
    logic any_wr;
    assign strobe = ~processor_addr_strobe_n | ~controller_addr_strobe_n;
    assign load_ok = strobe & ~chip_sel_n;
    assign any_wr = ~low_byte_wr_n | ~high_byte_wr_n;

    // ----------------------------------------------------------------
    // registered state
    // ----------------------------------------------------------------
    logic [`BSRAM_AW-1:0] base_r;
    logic [`BSRAM_CNT_W-1:0] cnt_r;
    logic [`BSRAM_CNT_W-1:0] cnt_nxt;
    logic [`BSRAM_LANES-1:0] we_r;
    logic [`BSRAM_DW-1:0] wdata_r;
    logic active_r;
    bsram_pkg::bsram_op_type op_r;
    bsram_pkg::bsram_op_type op_nxt;
    logic [`BSRAM_DW-1:0] data_o_r;
    logic drive_r;
    logic [`BSRAM_AW-1:0] eff_addr;
    logic [`BSRAM_DW-1:0] rdata;
    logic [`BSRAM_LANES-1:0] lane_we;

    // next operation and counter from the sampled controls
    always_comb begin
        op_nxt = bsram_pkg::BSRAM_IDLE;
        cnt_nxt = cnt_r;
        if (strobe) begin
            cnt_nxt = `BSRAM_CNT_RST;
            if (chip_sel_n) begin
                op_nxt = bsram_pkg::BSRAM_IDLE;
            end else if (~processor_addr_strobe_n) begin
                op_nxt = bsram_pkg::BSRAM_READ;
            end else if (any_wr) begin
                op_nxt = bsram_pkg::BSRAM_WRITE;
            end else begin
                op_nxt = bsram_pkg::BSRAM_READ;
            end
        end else if (active_r) begin
            if (~burst_step_n) begin
                cnt_nxt = cnt_r + 2'h1;
            end
            op_nxt = any_wr ? bsram_pkg::BSRAM_WRITE : bsram_pkg::BSRAM_READ;
        end
    end

    // base address captured only on a selected load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_r <= `BSRAM_ADDR_RST;
        end else if (load_ok) begin
            base_r <= addr_in;
        end
    end

    // burst counter, operation and burst-alive flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= `BSRAM_CNT_RST;
            op_r <= bsram_pkg::BSRAM_IDLE;
            active_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            op_r <= op_nxt;
            if (strobe) begin
                active_r <= ~chip_sel_n;
            end
        end
    end

    // write data and lane enables; processor strobe start never writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            we_r <= `BSRAM_WE_RST;
            wdata_r <= `BSRAM_DATA_RST;
        end else begin
            wdata_r <= data_io_i;
            if (op_nxt == bsram_pkg::BSRAM_WRITE) begin
                we_r <= {~high_byte_wr_n, ~low_byte_wr_n};
            end else begin
                we_r <= `BSRAM_WE_RST;
            end
        end
    end

    // ----------------------------------------------------------------
    // burst address and array
    // ----------------------------------------------------------------
    // upper bits fixed, low bits interleaved by the count
    assign eff_addr = {base_r[`BSRAM_AW-1:`BSRAM_CNT_W], base_r[`BSRAM_CNT_W-1:0] ^ cnt_r};
    assign lane_we = we_r;

    bsram_array u_array (
        .clk(clk),
        .addr(eff_addr),
        .lane_we(lane_we),
        .wdata(wdata_r),
        .rdata(rdata)
    );

    // ----------------------------------------------------------------
    // output register and pin drive
    // ----------------------------------------------------------------
    // read data captured one edge after sampling; drive only after a read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_o_r <= `BSRAM_DATA_RST;
            drive_r <= 1'b0;
        end else begin
            if (op_r == bsram_pkg::BSRAM_READ) begin
                data_o_r <= rdata;
            end
            drive_r <= (op_r == bsram_pkg::BSRAM_READ);
        end
    end

    assign data_io_o = data_o_r;
    // output enable gates the pins without the clock
    assign data_io_oe_n = ~drive_r | out_en_n;

    // ----------------------------------------------------------------
    // checks: output pipeline and pin drive
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // a read cycle shows its word one edge later
    read_pipe_a: assert property (op_r == bsram_pkg::BSRAM_READ |=> drive_r && data_o_r == $past(rdata))
        else $error("read data not registered one edge later");
    // output register keeps its word over cycles that do not read
    out_hold_a: assert property (op_r != bsram_pkg::BSRAM_READ |=> $stable(data_o_r))
        else $error("output register changed without a read");
    // writes and idle cycles leave the pins released
    no_drive_a: assert property (op_r != bsram_pkg::BSRAM_READ |=> data_io_oe_n)
        else $error("pins driven after write or deselect");
    // output enable high always releases the pins, whatever the clock did
    oe_gate_a: assert property (out_en_n |-> data_io_oe_n)
        else $error("pins driven with output enable high");

    // ----------------------------------------------------------------
    // checks: burst start and deselect
    // ----------------------------------------------------------------
    // selected strobe loads the base and clears the count
    base_load_a: assert property (load_ok |=> base_r == $past(addr_in) && cnt_r == 2'h0)
        else $error("base address not loaded");
    // processor strobe always reads, write enables ignored
    ps_read_a: assert property (~processor_addr_strobe_n && ~chip_sel_n
        |=> op_r == bsram_pkg::BSRAM_READ && we_r == 2'h0)
        else $error("processor strobe start not a read");
    // controller strobe with any enable low writes the enabled lanes
    cs_write_a: assert property (processor_addr_strobe_n && ~controller_addr_strobe_n && ~chip_sel_n
        && any_wr |=> op_r == bsram_pkg::BSRAM_WRITE && we_r == $past({~high_byte_wr_n, ~low_byte_wr_n}))
        else $error("controller strobe write start wrong");
    // controller strobe with both enables high reads
    cs_read_a: assert property (processor_addr_strobe_n && ~controller_addr_strobe_n && ~chip_sel_n
        && !any_wr |=> op_r == bsram_pkg::BSRAM_READ && we_r == 2'h0)
        else $error("controller strobe read start wrong");
    // strobe with chip select high performs no access
    desel_a: assert property (strobe && chip_sel_n |=> op_r == bsram_pkg::BSRAM_IDLE ##1 data_io_oe_n)
        else $error("deselect performed an access");
    // deselect kills the burst until the next selected load
    desel_dead_a: assert property (strobe && chip_sel_n |=> !active_r)
        else $error("burst still alive after deselect");
    // a dead burst stays idle whatever the other controls do
    dead_idle_a: assert property (!strobe && !active_r |=> op_r == bsram_pkg::BSRAM_IDLE && we_r == 2'h0)
        else $error("access while deselected");

    // ----------------------------------------------------------------
    // checks: burst stepping
    // ----------------------------------------------------------------
    // step low advances the count by one
    step_a: assert property (!strobe && active_r && ~burst_step_n |=> cnt_r == $past(cnt_r) + 2'h1)
        else $error("burst did not advance");
    // step high is a wait state: nothing moves
    hold_a: assert property (!strobe && burst_step_n |=> $stable(cnt_r) && $stable(base_r))
        else $error("burst moved on a wait state");
    // four advances bring the burst back to the address it was loaded with
    wrap_a: assert property (load_ok ##1 (!strobe && active_r && ~burst_step_n) [*4]
        |=> eff_addr == $past(addr_in, 5))
        else $error("burst did not wrap to start");
    // the counter never carries into the upper address bits
    upper_fix_a: assert property (!load_ok |=>
        eff_addr[`BSRAM_AW-1:`BSRAM_CNT_W] == $past(eff_addr[`BSRAM_AW-1:`BSRAM_CNT_W]))
        else $error("upper address bits moved inside a burst");
    // continuing cycles ignore chip select and follow the enables
    cont_op_a: assert property (!strobe && active_r |=> we_r == $past({~high_byte_wr_n, ~low_byte_wr_n})
        && op_r != bsram_pkg::BSRAM_IDLE)
        else $error("continuing cycle lost its operation");

    // ----------------------------------------------------------------
    // coverage of the main scenarios
    // ----------------------------------------------------------------
    // read and write bursts, strobe-started write, wait state, deselect
    burst_read_c: cover property (load_ok && ~processor_addr_strobe_n ##1 (!strobe && ~burst_step_n) [*3]);
    burst_write_c: cover property (load_ok && any_wr && processor_addr_strobe_n ##1 (!strobe && any_wr) [*3]);
    ps_write_c: cover property (~processor_addr_strobe_n && ~chip_sel_n ##1 !strobe && any_wr);
    wait_c: cover property (active_r && !strobe && burst_step_n);
    desel_c: cover property (strobe && chip_sel_n ##1 !strobe && ~burst_step_n);
endmodule : bsram_core
`default_nettype wire

// [verilog/bsram_pkg.sv]
// types shared by the burst synchronous sram core
// assumes bsram_cfg.svh is on the include path
`default_nettype none
`include "bsram_cfg.svh"
package bsram_pkg;
    // operation latched for the current cycle
    typedef enum logic [1:0] {
        BSRAM_IDLE = 2'b00,
        BSRAM_READ = 2'b01,
        BSRAM_WRITE = 2'b10
    } bsram_op_type;
endpackage : bsram_pkg
`default_nettype wire
